// *** hdl/ipc_pkg.sv ***
// Contract
// RQ1 - Per input, configuration picks pulse catching on or off and a filter time.
// RQ2 - A caught pulse shows the image bit on for one scan, cleared at scan end.
// RQ3 - Catching triggers on a rising edge of the filtered input.
// RQ4 - Within one scan only the first pulse counts; later ones are dropped.
// RQ5 - The source spaces pulses at least one scan apart.
// RQ6 - Pulses caught in several scans give as many scans of image on.
// RQ7 - A pulse high for several scans still gives only one scan on.
// RQ8 - High and low times must both exceed the configured response time.
// RQ9 - Shortest response is 100 us on standard, 10 us on high-speed inputs.
// RQ10 - Standard and high-speed inputs each offer six selectable response times.
// RQ11 - Pulse catching is available on all sixteen built-in inputs.
// RQ12 - The program uses no direct access or mid-scan refresh on catch inputs.
// RQ13 - The filter accepts a new level only after it holds for the response time.
// RQ14 - A per-input latch holds the pulse until the next image refresh clears it.
package ipc_pkg;
    // ==========================================================
    // Sizes
    localparam int NUM_IN = 16;
    localparam int NUM_STD = 10;
    localparam int CNT_W = 20;
    localparam int CLK_HZ = 10000000;
    // ==========================================================
    // Response times in microseconds
    localparam int STD_US [6] = '{100, 1000, 5000, 10000, 20000, 70000};
    localparam int HS_US [6] = '{10, 100, 200, 400, 600, 1000};
    // ==========================================================
    // Register map
    localparam logic [11:0] ADDR_CATCH_EN = 12'h000;
    localparam logic [11:0] ADDR_SEL_LO = 12'h004;
    localparam logic [11:0] ADDR_SEL_HI = 12'h008;
    localparam logic [11:0] ADDR_IMAGE = 12'h00C;
    localparam logic [11:0] ADDR_FILTERED = 12'h010;
    localparam logic [11:0] ADDR_SCAN = 12'h014;
    localparam logic [11:0] ADDR_IRQ_STAT = 12'h018;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h01C;
    localparam logic [11:0] ADDR_LATCH = 12'h020;
    localparam logic [15:0] CATCH_EN_RST = 16'h0000;
    localparam logic [31:0] SEL_RST = 32'h00000000;
    localparam logic [15:0] MASK_RST = 16'h0000;
    localparam int SEL_W = 3;
    localparam int SCAN_END_BIT = 0;
    localparam int SCAN_REFRESH_BIT = 1;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    // ==========================================================
    // Bus carriers
    typedef struct packed {
        logic sel;
        logic [31:0] addr;
        logic [1:0] trans;
        logic write;
        logic [2:0] size;
        logic ready;
    } ipc_ahb_req_t;
    typedef struct packed {
        logic ready;
        logic resp;
        logic [31:0] rdata;
    } ipc_ahb_rsp_t;
    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_DATA = 1'b1
    } ipc_bus_state_t;

    // Filter time in cycles for an input and a selection code
    function automatic logic [CNT_W-1:0] ipc_filter_cycles(
        input int idx,
        input logic [SEL_W-1:0] sel
    );
        int us;
        int s;
        s = (sel > 3'h5) ? 5 : int'(sel);
        us = (idx < NUM_STD) ? STD_US[s] : HS_US[s]; // RQ9 RQ10
        return CNT_W'(us * (CLK_HZ / 1000000));
    endfunction
endpackage

// *** hdl/ipc_filter.sv ***
`timescale 1ns/10ps
module ipc_filter
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic raw_in,
    input wire logic [ipc_pkg::CNT_W-1:0] hold_cycles,
    output logic level_r
);
    import ipc_pkg::*;
    logic [CNT_W-1:0] cnt_r;

    // ==========================================================
    // Debounce: change only after a continuous hold
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_r <= '0;
            level_r <= 1'b0;
        end
        else if (raw_in == level_r)
        begin
            cnt_r <= '0;
        end
        else if (cnt_r + 1'b1 >= hold_cycles)
        begin
            level_r <= raw_in; // RQ13 RQ8
            cnt_r <= '0;
        end
        else
        begin
            cnt_r <= cnt_r + 1'b1;
        end
    end
endmodule // ipc_filter

// *** hdl/ipc_ahb_slave.sv ***
`timescale 1ns/10ps
module ipc_ahb_slave
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire ipc_pkg::ipc_ahb_req_t req,
    output logic wr_stb,
    output logic rd_stb,
    output logic [11:0] reg_addr_r,
    output ipc_pkg::ipc_bus_state_t state_r
);
    import ipc_pkg::*;
    logic take;

    assign take = req.sel && req.ready && req.trans == HTRANS_NONSEQ;
    // ==========================================================
    // Address phase capture
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r <= BUS_IDLE;
            reg_addr_r <= '0;
        end
        else
        begin
            case (state_r)
                BUS_IDLE:
                begin
                    if (take && req.write)
                    begin
                        state_r <= BUS_DATA;
                    end
                    reg_addr_r <= req.addr[11:0];
                end
                BUS_DATA:
                begin
                    state_r <= BUS_IDLE;
                    if (take)
                    begin
                        state_r <= req.write ? BUS_DATA : BUS_IDLE;
                    end
                    reg_addr_r <= req.addr[11:0];
                end
                default:
                begin
                    state_r <= BUS_IDLE;
                end
            endcase
        end
    end
    assign wr_stb = state_r == BUS_DATA;
    assign rd_stb = take && !req.write;
endmodule // ipc_ahb_slave

// *** hdl/ipc_top.sv ***
// Design decisions made here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/10ps
module ipc_top
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [15:0] ext_in,
    input wire logic scan_end,
    output logic [15:0] image_r,
    output logic irq
);
    import ipc_pkg::*;

    ipc_ahb_req_t req;
    ipc_bus_state_t bus_state;
    logic wr_stb;
    logic rd_stb;
    logic [11:0] reg_addr;
    logic [15:0] catch_en_r;
    logic [31:0] sel_lo_r;
    logic [31:0] sel_hi_r;
    logic [15:0] filt;
    logic [15:0] filt_d_r;
    logic [15:0] latch_r;
    logic [15:0] done_r;
    logic [15:0] rise;
    logic [15:0] caught;
    logic [15:0] irq_stat_r;
    logic [15:0] irq_mask_r;
    logic [15:0] w16;
    logic sw_end;
    logic sw_refresh;
    logic end_evt;
    logic [47:0] sel_all;

    assign req = '{sel: hsel, addr: haddr, trans: htrans, write: hwrite,
                   size: hsize, ready: hready};
    assign w16 = hwdata[15:0];

    // ==========================================================
    // Bus slave
    ipc_ahb_slave u_bus
    (
        .mclk(mclk),
        .arst_n(arst_n),
        .req(req),
        .wr_stb(wr_stb),
        .rd_stb(rd_stb),
        .reg_addr_r(reg_addr),
        .state_r(bus_state)
    );
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ==========================================================
    // Configuration registers
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            catch_en_r <= CATCH_EN_RST;
            sel_lo_r <= SEL_RST;
            sel_hi_r <= SEL_RST;
            irq_mask_r <= MASK_RST;
        end
        else if (wr_stb)
        begin
            case (reg_addr)
                ADDR_CATCH_EN: catch_en_r <= w16; // RQ1 RQ11
                ADDR_SEL_LO: sel_lo_r <= hwdata; // RQ1
                ADDR_SEL_HI: sel_hi_r <= hwdata; // RQ1
                ADDR_IRQ_MASK: irq_mask_r <= w16;
                default: ;
            endcase
        end
    end

    // Software scan control pulses
    assign sw_end = wr_stb && reg_addr == ADDR_SCAN && hwdata[SCAN_END_BIT];
    assign sw_refresh = wr_stb && reg_addr == ADDR_SCAN
                        && hwdata[SCAN_REFRESH_BIT];
    assign end_evt = scan_end || sw_end;
    assign sel_all = {sel_hi_r[23:0], sel_lo_r[23:0]};

    // ==========================================================
    // Per-input response filters
    for (genvar i = 0; i < NUM_IN; i++)
    begin : g_in
        ipc_filter u_filt
        (
            .mclk(mclk),
            .arst_n(arst_n),
            .raw_in(ext_in[i]),
            .hold_cycles(ipc_filter_cycles(i, sel_all[i*SEL_W +: SEL_W])),
            .level_r(filt[i])
        );
    end

    // ==========================================================
    // Edge catch
    assign rise = filt & ~filt_d_r & catch_en_r; // RQ3
    // A rise in the scan end cycle opens the new scan
    assign caught = end_evt ? rise : (rise & ~done_r); // RQ4
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            filt_d_r <= '0;
            latch_r <= '0;
            done_r <= '0;
        end
        else
        begin
            filt_d_r <= filt;
            if (end_evt)
            begin
                // Refresh moves latch to image and rearms
                latch_r <= rise; // RQ14 RQ6
                done_r <= rise; // RQ4
            end
            else
            begin
                latch_r <= latch_r | (rise & ~done_r); // RQ4 RQ7
                done_r <= done_r | rise; // RQ4
            end
        end
    end

    // ==========================================================
    // Input image
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            image_r <= '0;
        end
        else if (end_evt)
        begin
            // One scan on for caught inputs; others track the filter
            image_r <= (latch_r & catch_en_r) | (filt & ~catch_en_r); // RQ2
        end
        else if (sw_refresh)
        begin
            image_r <= (image_r & catch_en_r) | (filt & ~catch_en_r); // RQ12
        end
    end

    // ==========================================================
    // Interrupt status, write one to clear, set wins
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irq_stat_r <= '0;
        end
        else
        begin
            irq_stat_r <= (irq_stat_r
                & ~((wr_stb && reg_addr == ADDR_IRQ_STAT) ? w16 : 16'h0000))
                | caught;
        end
    end
    assign irq = |(irq_stat_r & irq_mask_r);

    // ==========================================================
    // Read data
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            hrdata <= '0;
        end
        else if (rd_stb)
        begin
            case (req.addr[11:0])
                ADDR_CATCH_EN: hrdata <= {16'h0000, catch_en_r};
                ADDR_SEL_LO: hrdata <= sel_lo_r;
                ADDR_SEL_HI: hrdata <= sel_hi_r;
                ADDR_IMAGE: hrdata <= {16'h0000, image_r};
                ADDR_FILTERED: hrdata <= {16'h0000, filt};
                ADDR_IRQ_STAT: hrdata <= {16'h0000, irq_stat_r};
                ADDR_IRQ_MASK: hrdata <= {16'h0000, irq_mask_r};
                ADDR_LATCH: hrdata <= {16'h0000, latch_r};
                default: hrdata <= '0;
            endcase
        end
    end
endmodule // ipc_top

// *** verif/ipc_top_asserts.sv ***
`timescale 1ns/10ps
module ipc_top_asserts
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic [15:0] ext_in,
    input wire logic scan_end,
    input wire logic [15:0] image_r,
    input wire logic irq
);
    import ipc_pkg::*;
    logic rd_take;
    logic wr_take;
    logic wph_r;
    assign rd_take = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
    assign wr_take = hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
    // ==========================================================
    // Write data phase marker
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            wph_r <= 1'b0;
        else
            wph_r <= wr_take;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // ==========================================================
    // Properties
    a_ready_high: assert property (hreadyout)
        else $error("hreadyout low");
    a_resp_okay: assert property (!hresp)
        else $error("hresp not okay");
    a_reset_clear: assert property ($rose(arst_n) |->
        image_r == 16'h0000 && !irq && hrdata == 32'h00000000)
        else $error("outputs not cleared by reset");
    a_rdata_hold: assert property ($changed(hrdata) |-> $past(rd_take))
        else $error("hrdata moved without a read");
    a_unmapped_zero: assert property (rd_take && haddr[11:0] >= 12'h024
        |=> hrdata == 32'h00000000)
        else $error("unmapped read not zero");
    a_image_scan_only: assert property ($changed(image_r) |->
        $past(scan_end) || $past(wph_r) || $past(wph_r, 2))
        else $error("image changed outside scan end");
    a_irq_sticky: assert property (irq && !wph_r |=> irq)
        else $error("irq dropped without a write");
    a_irq_cause: assert property ($rose(irq) |-> $past(wph_r) ||
        ($past(ext_in, 3) != 16'h0000 && $past(ext_in, 60) != 16'h0000))
        else $error("irq rose without a filtered input");
    c_image_on: cover property (scan_end ##1 image_r != 16'h0000);
    c_irq_rise: cover property ($rose(irq));
    c_read: cover property (rd_take);
endmodule // ipc_top_asserts

bind ipc_top ipc_top_asserts u_chk (.mclk(mclk), .arst_n(arst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .ext_in(ext_in), .scan_end(scan_end),
    .image_r(image_r), .irq(irq));

// *** verif/ipc_sensor_model.sv ***
`timescale 1ns/10ps
module ipc_sensor_model
(
    input wire logic mclk,
    output logic [15:0] ext_in
);
    initial ext_in = 16'h0000;
    // ==========================================================
    // One pulse with its high and low time in clock cycles
    task automatic pulse(input int idx, input int hi, input int lo);
        ext_in[idx] <= 1'b1;
        repeat (hi) @(posedge mclk);
        ext_in[idx] <= 1'b0;
        repeat (lo) @(posedge mclk);
    endtask
endmodule // ipc_sensor_model

// *** verif/tb.sv ***
`timescale 1ns/10ps
module tb;
    import ipc_pkg::*;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h00000000;
    logic scan_end = 1'b0;
    logic hreadyout;
    logic hresp;
    logic irq;
    logic [31:0] hrdata;
    logic [31:0] q;
    logic [15:0] ext_in;
    logic [15:0] image_r;
    int num_errors = 0;
    int checks = 0;
    int cyc = 0;
    always #50 mclk = ~mclk;
    ipc_sensor_model SNS (.mclk(mclk), .ext_in(ext_in));
    ipc_top DUT (.mclk(mclk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(HSIZE_WORD),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .ext_in(ext_in),
        .scan_end(scan_end), .image_r(image_r), .irq(irq));
    // ==========================================================
    // Shared tasks
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            $display("Error %s expected %h seen %h", nm, e, g);
            num_errors++;
        end
    endtask
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task rd(input string nm, input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h00000000);
        chk(nm, e, q);
    endtask
    task scan(input logic [15:0] e);
        scan_end <= 1'b1;
        @(posedge mclk);
        scan_end <= 1'b0;
        @(posedge mclk);
        chk("image", {16'h0000, e}, {16'h0000, image_r});
    endtask
    task give_verdict;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    task t_regs;
        rd("catch_en", ADDR_CATCH_EN, {16'h0000, CATCH_EN_RST});
        rd("sel_lo", ADDR_SEL_LO, SEL_RST);
        rd("mask", ADDR_IRQ_MASK, {16'h0000, MASK_RST});
        rd("unmapped", 32'h00000030, 32'h00000000);
        bus(1'b1, ADDR_CATCH_EN, 32'hFFFFFFFF);
        rd("catch_en", ADDR_CATCH_EN, 32'h0000FFFF);
        bus(1'b1, ADDR_IMAGE, 32'h0000FFFF);
        rd("image ro", ADDR_IMAGE, 32'h00000000);
        bus(1'b1, ADDR_IRQ_MASK, 32'h00000400);
    endtask
    task t_first_only;
        SNS.pulse(10, 150, 150);
        chk("irq", 32'h00000001, {31'h0, irq});
        SNS.pulse(10, 150, 150);
        rd("latch", ADDR_LATCH, 32'h00000400);
        scan(16'h0400);
        rd("latch", ADDR_LATCH, 32'h00000000);
        scan(16'h0000);
        bus(1'b1, ADDR_IRQ_STAT, 32'h00000400);
        @(posedge mclk);
        chk("irq", 32'h00000000, {31'h0, irq});
        rd("irq_stat", ADDR_IRQ_STAT, 32'h00000000);
    endtask
    task t_per_scan;
        repeat (2)
        begin
            SNS.pulse(10, 150, 150);
            scan(16'h0400);
        end
        scan(16'h0000);
    endtask
    task t_long;
        fork
            SNS.pulse(11, 400, 150);
            begin
                repeat (150) @(posedge mclk);
                scan(16'h0800);
                repeat (100) @(posedge mclk);
                scan(16'h0000);
            end
        join
        scan(16'h0000);
    endtask
    task t_filter;
        int idx [6] = '{12, 0, 0, 13, 13, 14};
        int sel [6] = '{0, 0, 0, 1, 1, 7};
        int hi [6] = '{50, 900, 1100, 500, 1100, 1100};
        int us;
        bus(1'b1, ADDR_IRQ_STAT, 32'h0000FFFF);
        for (int i = 0; i < 6; i++)
        begin
            us = idx[i] < NUM_STD ? STD_US[sel[i] > 5 ? 5 : sel[i]] :
                HS_US[sel[i] > 5 ? 5 : sel[i]];
            bus(1'b1, idx[i] < 8 ? ADDR_SEL_LO : ADDR_SEL_HI,
                32'(sel[i]) << (3 * (idx[i] % 8)));
            SNS.pulse(idx[i], hi[i], 1100);
            scan(hi[i] > us * 10 ? 16'(1 << idx[i]) : 16'h0000);
        end
        chk("irq masked", 32'h00000000, {31'h0, irq});
        rd("irq_stat", ADDR_IRQ_STAT, 32'h00002001);
    endtask
    task t_sw_scan;
        bus(1'b1, ADDR_CATCH_EN, 32'h0000F7FF);
        fork
            SNS.pulse(11, 300, 150);
            begin
                repeat (200) @(posedge mclk);
                rd("filtered", ADDR_FILTERED, 32'h00000800);
                bus(1'b1, ADDR_SCAN, 32'h00000002);
                rd("refresh", ADDR_IMAGE, 32'h00000800);
            end
        join
        SNS.pulse(10, 150, 150);
        chk("irq", 32'h00000001, {31'h0, irq});
        bus(1'b1, ADDR_SCAN, 32'h00000002);
        rd("refresh", ADDR_IMAGE, 32'h00000000);
        bus(1'b1, ADDR_SCAN, 32'h00000001);
        rd("sw end", ADDR_IMAGE, 32'h00000400);
        scan(16'h0000);
    endtask
    // ==========================================================
    // Main sequence and hang guard
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            num_errors++;
            give_verdict;
        end
    end
    initial
    begin
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        t_regs;
        t_first_only;
        t_per_scan;
        t_long;
        t_filter;
        t_sw_scan;
        give_verdict;
    end
endmodule // tb
